// file: shared/pin_level_c_hi_map.svh
// register offsets, field positions, reset values for the upper port pin mux
`ifndef PIN_LEVEL_C_HI_MAP_SVH
`define PIN_LEVEL_C_HI_MAP_SVH
`define PIN_LEVEL_C_OFS 4'h0
`define OUTPUT_LATCH_C_OFS 4'h1
`define DIRECTION_C_OFS 4'h2
`define ANALOG_SELECT_C_OFS 4'h3
`define SLEW_RATE_CONTROL_OFS 4'h4
`define PIN_CFG_OFS 4'h5
`define PERIPH_EN_OFS 4'h6
`define DIRECTION_C_RST 8'hff
`define ANALOG_SELECT_C_RST 8'hfc
`define OUTPUT_LATCH_C_RST 8'h00
`define SLEW_RATE_CONTROL_RST 8'h1f
`define PIN_CFG_RST 8'h3f
`define PERIPH_EN_RST 8'h00
`define ANSEL_IMPL_MASK 8'hfc
`define SLEW_IMPL_MASK 8'h1f
`define CFG_UNIT2_BIT 0
`define CFG_UNIT3_BIT 2
`define CFG_TIMER3_BIT 4
`define CFG_PWMB_BIT 5
`define EN_SPI_BIT 0
`define EN_PWM_A_BIT 1
`define EN_PWM_B_BIT 2
`define EN_CCP_BIT 3
`define EN_SERIAL_BIT 4
`define EN_SYNC_BIT 5
`define EN_CLK_MASTER_BIT 6
`endif

// file: shared/pin_level_c_hi_pkg.sv
// types shared by the upper port pin mux
package pin_level_c_hi_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] reg_addr_t;
   // who owns a pin output driver
   typedef enum logic [2:0] {
      OWN_NONE,
      OWN_LATCH,
      OWN_SPI,
      OWN_PWM,
      OWN_CCP,
      OWN_SERIAL
   } pin_owner_t;
endpackage

// file: tb/board_model.sv
// board wiring: pin level from chip drive or board source
`timescale 1ns/1ps
module board_model (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] ext,
   output logic [2:0] pin_in
);
   // chip driver wins where enabled, else the board source
   assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule

// file: tb/pin_level_c_hi_asserts.sv
// port-level assertions for the upper port pin mux
`timescale 1ns/1ps
module pin_level_c_hi_asserts
   import pin_level_c_hi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire pin_level_c_hi_pkg::reg_addr_t reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire pin_level_c_hi_pkg::byte_t reg_rdata,
   input wire logic [2:0] pin_in,
   input wire logic [2:0] pin_oe,
   input wire logic async_receive_first,
   input wire logic capture_compare_unit3_pin_capture_in,
   input wire logic analog_channel_17,
   input wire logic analog_channel_19
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // read data only stands after a read
   property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle)
      else $error("read data without a read");
   property p_pinrd; reg_rd && reg_addr == 4'h0 |=> reg_rdata[4:0] == 5'h00;
   endproperty
   a_pinrd: assert property (p_pinrd)
      else $error("pin level low bits not zero");
   property p_ansrd; reg_rd && reg_addr == 4'h3 |=> reg_rdata[1:0] == 2'h0;
   endproperty
   a_ansrd: assert property (p_ansrd)
      else $error("analog select low bits not zero");
   // analog taps follow the pin itself
   property p_ch17; analog_channel_17 |-> pin_in[0]; endproperty
   a_ch17: assert property (p_ch17)
      else $error("channel 17 high with pin low");
   property p_ch19; analog_channel_19 |-> pin_in[2]; endproperty
   a_ch19: assert property (p_ch19)
      else $error("channel 19 high with pin low");
   // inputs pass one flop behind the pin
   property p_rx; async_receive_first |-> $past(pin_in[2]); endproperty
   a_rx: assert property (p_rx)
      else $error("receive high without pin high");
   property p_cap; capture_compare_unit3_pin_capture_in |-> $past(pin_in[1]); endproperty
   a_cap: assert property (p_cap)
      else $error("capture high without pin high");
   // bit5 and bit6 drivers only move two edges after a register write
   property p_oe5; $changed(pin_oe[0]) |-> $past(reg_wr, 2); endproperty
   a_oe5: assert property (p_oe5)
      else $error("bit5 enable moved without write");
   property p_oe6; $changed(pin_oe[1]) |-> $past(reg_wr, 2); endproperty
   a_oe6: assert property (p_oe6)
      else $error("bit6 enable moved without write");
   c_rd: cover property (reg_rd && reg_addr == 4'h0);
   c_drv: cover property (pin_oe == 3'h7);
   c_an: cover property (analog_channel_19);
endmodule

// file: tb/tb_top.sv
// self-checking bench for the upper port pin mux
`timescale 1ns/1ps
module tb_top;
   import pin_level_c_hi_pkg::*;
   logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
   reg_addr_t reg_addr = 4'h0;
   byte_t reg_wdata = 8'h00, reg_rdata;
   logic [2:0] pin_in, pin_out, pin_oe, ext = 3'h0;
   logic [7:0] pv = 8'h00; // peripheral levels
   logic cap, rx, sck, sdi, a17, a18, a19, c2, c3t, cpb;
   byte_t lat, dir, an, cfg, en; // register mirror
   int mismatches = 0, compares = 0, cyc = 0;
   byte_t rst[8] = '{8'h00, 8'h00, 8'hff, 8'hfc, 8'h1f, 8'h3f, 8'h00, 8'h00};
   byte_t tab[10][3] = '{'{8'h00, 8'h01, 8'h3f}, '{8'h00, 8'h02, 8'h3b},
      '{8'h00, 8'h04, 8'h3f}, '{8'h00, 8'h08, 8'h0a}, '{8'h00, 8'h0a, 8'h3f},
      '{8'h00, 8'h0a, 8'h3b}, '{8'hff, 8'h10, 8'h3f}, '{8'hff, 8'h70, 8'h3f},
      '{8'hff, 8'h30, 8'h3f}, '{8'h20, 8'h1f, 8'h3b}}; // {dir, en, cfg}
   always #12.5 ref_clk = ~ref_clk;
   board_model brd (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
      .pin_in(pin_in));
   pin_level_c_hi_mux dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .spi_serial_out_first(pv[0]),
      .unit3_pwm_out_a(pv[1]), .unit3_pwm_out_b(pv[2]),
      .capture_compare_unit3_pin_compare_out(pv[3]), .async_transmit_first(pv[4]),
      .sync_clock_out(pv[5]), .sync_data_out(pv[6]),
      .sync_data_drive(pv[7]), .capture_compare_unit3_pin_capture_in(cap),
      .async_receive_first(rx), .sync_clock_in(sck), .sync_data_in(sdi),
      .analog_channel_17(a17), .analog_channel_18(a18),
      .analog_channel_19(a19), .unit2_pin_select_cfg(c2),
      .timer3_clock_pin_select_cfg(c3t), .unit2_pwm_b_pin_select_cfg(cpb));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input reg_addr_t a, input byte_t d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read, data looked at in the cycle after the strobe
   task automatic rdc(input reg_addr_t a, input byte_t e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic setw(input byte_t d, input byte_t a, input byte_t e,
      input byte_t c);
      dir = d;
      an = a;
      en = e;
      cfg = c;
      wr(4'h2, d);
      wr(4'h3, a);
      wr(4'h6, e);
      wr(4'h5, c);
   endtask
   // expected {enables, levels}: serial, capture_compare_unit3_pin, pwm, spi, latch
   function automatic logic [5:0] exp_pins();
      logic s6, s7;
      logic [2:0] o, e;
      s6 = en[4] & (~en[5] | en[6]);
      s7 = en[4] & en[5] & pv[7];
      e = {s7 | ~dir[7], s6 | ~dir[6], ~dir[5]};
      o[0] = en[0] ? pv[0] : lat[5];
      o[1] = s6 ? (en[5] ? pv[5] : pv[4]) :
         (en[3] & ~cfg[2]) ? pv[3] : (en[1] & ~cfg[2]) ? pv[1] : lat[6];
      o[2] = s7 ? pv[6] : en[2] ? pv[2] : lat[7];
      return {e, o & e};
   endfunction
   task automatic pins();
      repeat (3) @(posedge ref_clk);
      #1 chk({2'b00, pin_oe, pin_out & pin_oe}, {2'b00, exp_pins()});
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'h4e4f));
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) rdc(4'(i), rst[i]);
      wr(4'h3, 8'hff);
      rdc(4'h3, 8'hfc);
      wr(4'h4, 8'hff);
      rdc(4'h4, 8'h1f);
      $display("test registers done");
      lat = 8'($urandom);
      wr(4'h0, lat);
      setw(8'h00, 8'h00, 8'h00, 8'h3f);
      pins();
      rdc(4'h1, lat);
      rdc(4'h0, {lat[7:5], 5'h00});
      setw(8'h00, 8'hff, 8'h00, 8'h3f);
      pins();
      $display("test latch done");
      for (int i = 0; i < 4; i++) begin
         setw(8'hff, 8'h00, 8'h00, 8'h3b);
         @(posedge ref_clk);
         ext <= 3'($urandom);
         repeat (3) @(posedge ref_clk);
         rdc(4'h0, {ext, 5'h00});
         chk({rx, sdi, cap, sck}, {{2{ext[2]}}, {2{ext[1]}}});
         setw(8'hff, 8'hff, 8'h00, 8'h3b);
         #1 chk({a19, a18, a17}, ext);
         rdc(4'h0, 8'h00);
      end
      $display("test inputs done");
      for (int i = 0; i < 10; i++) begin
         setw(tab[i][0], i[0] ? 8'hff : 8'h00, tab[i][1], tab[i][2]);
         // config outputs settle after the edge that takes the write
         #1 chk({c2, c3t, cpb}, {cfg[0], cfg[4], cfg[5]});
         for (int j = 0; j < 3; j++) begin
            @(posedge ref_clk);
            pv <= 8'($urandom);
            pins();
         end
         pins();
      end
      $display("test functions done");
      conclude();
   end
endmodule
bind pin_level_c_hi_mux pin_level_c_hi_asserts chk_i (.ref_clk, .reset_n, .reg_addr,
   .reg_rd, .reg_wr, .reg_rdata, .pin_in, .pin_oe, .async_receive_first,
   .capture_compare_unit3_pin_capture_in, .analog_channel_17, .analog_channel_19);

// file: verilog/pin_cell.sv
// one pin cell: registered output drive and enable, and gated digital input
`timescale 1ns/1ps
module pin_cell
   import pin_level_c_hi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic drv_en,
   input wire logic drv_val,
   input wire logic analog_sel,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic dig_in
);
   logic out_nxt;
   logic oe_nxt;
   logic din_nxt;
   logic out_r;
   logic oe_r;
   logic din_r;
   // next pin drive and digital input value
   always_comb begin
      out_nxt = drv_val;
      oe_nxt = drv_en;
      din_nxt = analog_sel ? 1'b0 : pin_in;
   end
   // register pin outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_r <= 1'b0;
         oe_r <= 1'b0;
         din_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         din_r <= din_nxt;
      end
   end
   assign pin_out = out_r;
   assign pin_oe = oe_r;
   assign dig_in = din_r;
endmodule

// file: verilog/pin_level_c_hi_mux.sv
// pin function mux for port bits 5 to 7 with register port
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_level_c_hi_map.svh"
module pin_level_c_hi_mux
   import pin_level_c_hi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire pin_level_c_hi_pkg::reg_addr_t reg_addr,
   input wire pin_level_c_hi_pkg::byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output pin_level_c_hi_pkg::byte_t reg_rdata,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   input wire logic spi_serial_out_first,
   input wire logic unit3_pwm_out_a,
   input wire logic unit3_pwm_out_b,
   input wire logic capture_compare_unit3_pin_compare_out,
   input wire logic async_transmit_first,
   input wire logic sync_clock_out,
   input wire logic sync_data_out,
   input wire logic sync_data_drive,
   output logic capture_compare_unit3_pin_capture_in,
   output logic async_receive_first,
   output logic sync_clock_in,
   output logic sync_data_in,
   output logic analog_channel_17,
   output logic analog_channel_18,
   output logic analog_channel_19,
   output logic unit2_pin_select_cfg,
   output logic timer3_clock_pin_select_cfg,
   output logic unit2_pwm_b_pin_select_cfg
);
   import pin_level_c_hi_pkg::*;

   logic rst_s1_r; // reset release stage one
   logic rst_n_r;  // reset release stage two
   byte_t latch_r, latch_nxt; // output latch
   byte_t dir_r, dir_nxt;     // direction, 1 = input
   byte_t ansel_r, ansel_nxt; // analog select
   byte_t slew_r, slew_nxt;   // slew rate control, stored only
   byte_t cfg_r, cfg_nxt;     // pin assignment configuration
   byte_t en_r, en_nxt;       // peripheral output enables
   byte_t rdata_r, rdata_nxt; // read data, one cycle after strobe
   logic [2:0] drv_en;        // driver enable per pin
   logic [2:0] drv_val;       // driven value per pin
   logic [2:0] dig_in;        // gated digital input per pin
   pin_owner_t own [3];       // owner per pin, for visibility
   logic capture_compare_unit3_pin_here;           // unit3 routed to bit6

   // two-stage reset release
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // pick highest priority owner; latch is the fallback
   function automatic pin_owner_t pick(input logic [4:0] req);
      if (req[4]) pick = OWN_SERIAL;
      else if (req[3]) pick = OWN_CCP;
      else if (req[2]) pick = OWN_PWM;
      else if (req[1]) pick = OWN_SPI;
      else if (req[0]) pick = OWN_LATCH;
      else pick = OWN_NONE;
   endfunction

   // unit3 on bit6 only under alternate assignment
   assign capture_compare_unit3_pin_here = !cfg_r[`CFG_UNIT3_BIT];
   // set bits keep the other functions on their default pins
   assign unit2_pin_select_cfg = cfg_r[`CFG_UNIT2_BIT];
   assign timer3_clock_pin_select_cfg = cfg_r[`CFG_TIMER3_BIT];
   assign unit2_pwm_b_pin_select_cfg = cfg_r[`CFG_PWMB_BIT];

   // output ownership and drive per pin
   always_comb begin
      logic [4:0] r5;
      logic [4:0] r6;
      logic [4:0] r7;
      // analog select does not enter any drive term
      r5 = '0;
      r6 = '0;
      r7 = '0;
      r5[0] = !dir_r[5];
      r5[1] = !dir_r[5] && en_r[`EN_SPI_BIT];
      r6[0] = !dir_r[6];
      r6[2] = !dir_r[6] && en_r[`EN_PWM_A_BIT] && capture_compare_unit3_pin_here;
      r6[3] = !dir_r[6] && en_r[`EN_CCP_BIT] && capture_compare_unit3_pin_here;
      // serial owns bit6 regardless of direction
      r6[4] = en_r[`EN_SERIAL_BIT] &&
         (!en_r[`EN_SYNC_BIT] || en_r[`EN_CLK_MASTER_BIT]);
      r7[0] = !dir_r[7];
      r7[2] = !dir_r[7] && en_r[`EN_PWM_B_BIT];
      r7[4] = en_r[`EN_SERIAL_BIT] && en_r[`EN_SYNC_BIT] &&
         sync_data_drive;
      own[0] = pick(r5);
      own[1] = pick(r6);
      own[2] = pick(r7);
      drv_en = {own[2] != OWN_NONE, own[1] != OWN_NONE,
         own[0] != OWN_NONE};
      unique case (own[0])
         OWN_SPI: drv_val[0] = spi_serial_out_first;
         default: drv_val[0] = latch_r[5];
      endcase
      unique case (own[1])
         OWN_SERIAL: drv_val[1] = en_r[`EN_SYNC_BIT] ?
            sync_clock_out : async_transmit_first;
         OWN_CCP: drv_val[1] = capture_compare_unit3_pin_compare_out;
         OWN_PWM: drv_val[1] = unit3_pwm_out_a;
         default: drv_val[1] = latch_r[6];
      endcase
      unique case (own[2])
         OWN_SERIAL: drv_val[2] = sync_data_out;
         OWN_PWM: drv_val[2] = unit3_pwm_out_b;
         default: drv_val[2] = latch_r[7];
      endcase
   end

   // one cell per pin; analog select gates the input path
   for (genvar i = 0; i < 3; i++) begin : g_pin
      pin_cell u_cell (
         .ref_clk(ref_clk),
         .rst_n(rst_n_r),
         .drv_en(drv_en[i]),
         .drv_val(drv_val[i]),
         .analog_sel(ansel_r[5+i]),
         .pin_in(pin_in[i]),
         .pin_out(pin_out[i]),
         .pin_oe(pin_oe[i]),
         .dig_in(dig_in[i])
      );
   end

   // peripheral inputs from the gated pin levels
   always_comb begin
      capture_compare_unit3_pin_capture_in = capture_compare_unit3_pin_here && dir_r[6] && dig_in[1];
      async_receive_first = dig_in[2];
      sync_clock_in = dig_in[1];
      sync_data_in = dig_in[2];
   end

   // analog channels fed when input and analog selected
   always_comb begin
      analog_channel_17 = dir_r[5] && ansel_r[5] && pin_in[0];
      analog_channel_18 = dir_r[6] && ansel_r[6] && pin_in[1];
      analog_channel_19 = dir_r[7] && ansel_r[7] && pin_in[2];
   end

   // register writes and read data
   always_comb begin
      latch_nxt = latch_r;
      dir_nxt = dir_r;
      ansel_nxt = ansel_r;
      slew_nxt = slew_r;
      cfg_nxt = cfg_r;
      en_nxt = en_r;
      rdata_nxt = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            `PIN_LEVEL_C_OFS: latch_nxt = reg_wdata;
            `OUTPUT_LATCH_C_OFS: latch_nxt = reg_wdata;
            `DIRECTION_C_OFS: dir_nxt = reg_wdata;
            `ANALOG_SELECT_C_OFS:
               ansel_nxt = reg_wdata & `ANSEL_IMPL_MASK;
            `SLEW_RATE_CONTROL_OFS:
               slew_nxt = reg_wdata & `SLEW_IMPL_MASK;
            `PIN_CFG_OFS: cfg_nxt = reg_wdata;
            `PERIPH_EN_OFS: en_nxt = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            // pins 0..4 live elsewhere and read zero here
            `PIN_LEVEL_C_OFS: rdata_nxt = {dig_in, 5'h00};
            `OUTPUT_LATCH_C_OFS: rdata_nxt = latch_r;
            `DIRECTION_C_OFS: rdata_nxt = dir_r;
            `ANALOG_SELECT_C_OFS: rdata_nxt = ansel_r;
            `SLEW_RATE_CONTROL_OFS: rdata_nxt = slew_r;
            `PIN_CFG_OFS: rdata_nxt = cfg_r;
            `PERIPH_EN_OFS: rdata_nxt = en_r;
            default: rdata_nxt = '0;
         endcase
      end
   end

   // register state
   always_ff @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         latch_r <= `OUTPUT_LATCH_C_RST;
         dir_r <= `DIRECTION_C_RST;
         ansel_r <= `ANALOG_SELECT_C_RST;
         slew_r <= `SLEW_RATE_CONTROL_RST;
         cfg_r <= `PIN_CFG_RST;
         en_r <= `PERIPH_EN_RST;
         rdata_r <= '0;
      end else begin
         latch_r <= latch_nxt;
         dir_r <= dir_nxt;
         ansel_r <= ansel_nxt;
         slew_r <= slew_nxt;
         cfg_r <= cfg_nxt;
         en_r <= en_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
endmodule
